// *** ffp_top.sv ***
// Decided for this implementation: the register offsets and register access over APB.
`default_nettype none
module ffp_top
	import ffp_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic LOCK_IN,
	input wire logic PENDING_IN,
	input wire logic FETCH_FLASH_IN,
	input wire ffp_fault_t FAULT_IN,
	input wire logic ERASE_OP_IN,
	input wire logic PROG_OP_IN,
	input wire logic [2:0] OP_SECTOR_IN,
	input wire logic [7:0] ERASE_SECTORS_IN,
	input wire logic [15:0] NV_WLOCK_IN,
	input wire logic [15:0] NV_ALOCK_IN,
	input wire logic [15:0] NV_DIS_IN,
	input wire logic [15:0] NV_REN_IN,
	input wire logic DATA_RD_IN,
	input wire logic DATA_WR_IN,
	input wire logic [31:0] FLASH_RDATA_IN,
	output logic [31:0] DATA_RDATA_OUT,
	output logic DATA_WR_OK_OUT,
	output logic TRAP_OUT,
	output logic [15:0] TRAP_CODE_OUT,
	output logic [7:0] SECTOR_WR_EN_OUT,
	output logic OP_ABORT_OUT,
	output logic DEBUG_EN_OUT,
	output logic BYPASS_ALL_OUT,
	output logic ACCESS_LOCK_OUT
);
	ffp_state_t st_q, st_d;
	ffp_prot_t prot_q, prot_d;
	logic [15:0] fault_q, fault_d;
	logic tau_q, tau_d;
	logic [1:0] psel_q, psel_d;
	logic pend_q, pend_d;
	logic [31:0] rdat_q, rdat_d;
	logic trap_q, trap_d;
	logic [31:0] dat_q, dat_d;
	logic [15:0] code_q, code_d;
	logic loaded;
	logic acc_lock;
	logic steps_off;
	logic wr_acc, rd_acc;
	logic [15:0] set_bits, clr_bits, prog_val, cur_val, legal;
	logic [15:0] dis_ok, ren_ok;
	logic [31:0] rd_mux;
	logic fault_done;

	assign loaded = (st_q == ST_RUN);
	assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign rd_acc = PSEL_IN && PENABLE_IN && !PWRITE_IN;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = 1'b0;
	assign PRDATA_OUT = rdat_q;

	// Disabled when some step is open: disable at 0, matching reenable at 1.
	assign steps_off = |(~prot_q.dis & prot_q.ren);
	assign acc_lock = !loaded || (!prot_q.alock[AB_ACCESS] && !steps_off &&
		!tau_q);
	assign ACCESS_LOCK_OUT = acc_lock;
	assign DEBUG_EN_OUT = loaded && prot_q.alock[AB_DEBUG];
	assign BYPASS_ALL_OUT = DEBUG_EN_OUT;
	// A sector is writable only when its volatile lock bit is erased.
	assign SECTOR_WR_EN_OUT = loaded ? prot_q.wlock[SECTORS-1:0] :
		8'h00;
	assign DATA_WR_OK_OUT = DATA_WR_IN && (!acc_lock || FETCH_FLASH_IN);
	assign fault_done = pend_q && !PENDING_IN && FAULT_IN.done;
	assign OP_ABORT_OUT = fault_done && FAULT_IN.resume_err;

	// Order a step may be programmed in, per cell.
	genvar g;
	assign dis_ok[0] = !prot_q.alock[AB_ACCESS] &&
		!prot_q.alock[AB_DEBUG];
	for (g = 1; g < STEPS; g++) begin : g_dis
		assign dis_ok[g] = !prot_q.ren[g-1];
	end
	for (g = 0; g < STEPS; g++) begin : g_ren
		assign ren_ok[g] = !prot_q.dis[g];
	end

	always_comb begin
		case (psel_q)
			SEL_NVWL: cur_val = prot_q.wlock;
			SEL_NVAL: cur_val = prot_q.alock;
			SEL_NVDIS: cur_val = prot_q.dis;
			default: cur_val = prot_q.ren;
		endcase
		case (psel_q)
			SEL_NVDIS: legal = dis_ok;
			SEL_NVREN: legal = ren_ok;
			default: legal = NV_ERASED;
		endcase
		// Only bits being turned to 0 that are allowed are taken.
		prog_val = cur_val & ~(~PWDATA_IN[15:0] & legal);
	end

	always_comb begin
		st_d = st_q;
		prot_d = prot_q;
		case (st_q)
			ST_RESET: st_d = ST_LOAD;
			ST_LOAD: begin
				prot_d.wlock = NV_WLOCK_IN;
				prot_d.alock = NV_ALOCK_IN;
				prot_d.dis = NV_DIS_IN;
				prot_d.ren = NV_REN_IN;
				st_d = ST_RUN;
			end
			ST_RUN: begin
				if (wr_acc && PADDR_IN == ADDR_PROG && !FETCH_FLASH_IN &&
					!acc_lock) begin
					case (psel_q)
						SEL_NVWL: prot_d.wlock = prog_val;
						SEL_NVAL: prot_d.alock = prog_val;
						SEL_NVDIS: prot_d.dis = prog_val;
						default: prot_d.ren = prog_val;
					endcase
				end
			end
			default: st_d = ST_RESET;
		endcase
	end

	always_comb begin
		psel_d = psel_q;
		tau_d = tau_q;
		if (wr_acc && PADDR_IN == ADDR_PROGSEL && !acc_lock) begin
			psel_d = PWDATA_IN[1:0];
		end
		if (wr_acc && PADDR_IN == ADDR_UNPROT && FETCH_FLASH_IN && loaded) begin
			tau_d = PWDATA_IN[0];
		end
	end

	always_comb begin
		set_bits = FAULT_RST;
		clr_bits = FAULT_RST;
		if (fault_done) begin
			set_bits[FB_WRITE] = FAULT_IN.write_err || FAULT_IN.seq_err ||
				FAULT_IN.erase_err || FAULT_IN.prog_err;
			set_bits[FB_ERASE] = FAULT_IN.erase_err;
			set_bits[FB_PROG] = FAULT_IN.prog_err;
			set_bits[FB_ONEZ] = FAULT_IN.one_zero;
			set_bits[FB_SEQ] = FAULT_IN.seq_err;
			set_bits[FB_RESUME] = FAULT_IN.resume_err;
			set_bits[FB_WPROT] = FAULT_IN.wprot ||
				((ERASE_OP_IN || PROG_OP_IN) && (PROG_OP_IN ?
				!SECTOR_WR_EN_OUT[OP_SECTOR_IN] :
				|(ERASE_SECTORS_IN & ~SECTOR_WR_EN_OUT)));
		end
		if (wr_acc && PADDR_IN == ADDR_FAULT && !acc_lock) begin
			clr_bits = ~PWDATA_IN[15:0] & FAULT_MASK;
		end
		fault_d = (fault_q & ~clr_bits) | set_bits;
		pend_d = PENDING_IN;
	end

	always_comb begin
		case (PADDR_IN)
			ADDR_FAULT: rd_mux = {16'h0000, fault_q};
			ADDR_NVWL: rd_mux = {16'h0000, prot_q.wlock};
			ADDR_NVAL: rd_mux = {16'h0000, prot_q.alock};
			ADDR_NVDIS: rd_mux = {16'h0000, prot_q.dis};
			ADDR_NVREN: rd_mux = {16'h0000, prot_q.ren};
			ADDR_UNPROT: rd_mux = {31'h0, tau_q};
			ADDR_PROGSEL: rd_mux = {30'h0, psel_q};
			ADDR_STATUS: rd_mux = {29'h0, acc_lock, loaded, LOCK_IN};
			default: rd_mux = 32'h0000_0000;
		endcase
		rdat_d = rdat_q;
		if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			// Locked controller or access lock from outside flash hides data.
			rdat_d = (LOCK_IN && PADDR_IN != ADDR_STATUS) ? DUMMY_DATA :
				rd_mux;
			if (acc_lock && !FETCH_FLASH_IN && PADDR_IN != ADDR_STATUS) begin
				rdat_d = DUMMY_DATA;
			end
		end
		trap_d = DATA_RD_IN && acc_lock && !FETCH_FLASH_IN;
		// A trapped read shows dummy data in the same cycle as its code.
		dat_d = trap_d ? DUMMY_DATA : FLASH_RDATA_IN;
		code_d = trap_d ? TRAP_CODE : 16'h0000;
	end

	assign TRAP_OUT = trap_q;
	assign TRAP_CODE_OUT = code_q;
	assign DATA_RDATA_OUT = dat_q;

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_q <= ST_RESET;
			prot_q <= {4{PROT_ACTIVE}};
		end else begin
			st_q <= st_d;
			prot_q <= prot_d;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tau_q <= 1'b0;
			psel_q <= SEL_NVWL;
		end else begin
			tau_q <= tau_d;
			psel_q <= psel_d;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fault_q <= FAULT_RST;
			pend_q <= 1'b0;
		end else begin
			fault_q <= fault_d;
			pend_q <= pend_d;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdat_q <= 32'h0000_0000;
			trap_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			code_q <= 16'h0000;
		end else begin
			rdat_q <= rdat_d;
			trap_q <= trap_d;
			dat_q <= dat_d;
			code_q <= code_d;
		end
	end

	// Every property below runs on the system clock and rests during reset.
	default clocking cb_sys @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RST_N_IN);

	a_fault_sticky: assert property (
		fault_done && FAULT_IN.seq_err |=>
		fault_q[FB_SEQ] && fault_q[FB_WRITE])
		else $error("sequence fault not latched");

	a_set_beats_clr: assert property (
		fault_done && FAULT_IN.prog_err |=> fault_q[FB_PROG])
		else $error("program fault lost");

	a_update_on_done: assert property (
		!fault_done && !wr_acc |=> fault_q == $past(fault_q))
		else $error("fault changed without cause");

	a_reset_active: assert property (
		!loaded |-> SECTOR_WR_EN_OUT == 8'h00 &&
		acc_lock && !DEBUG_EN_OUT)
		else $error("protection inactive before load");

	a_load_once: assert property (
		st_q == ST_LOAD |=>
		prot_q.wlock == $past(NV_WLOCK_IN) && loaded)
		else $error("load did not copy");

	a_otp_only: assert property (
		loaded |=> (prot_q.dis & ~$past(prot_q.dis)) == 16'h0000)
		else $error("protection bit went back to 1");

	a_setprot_flash: assert property (
		loaded && FETCH_FLASH_IN |=> prot_q == $past(prot_q))
		else $error("set protection from flash");

	a_trap_dummy: assert property (
		DATA_RD_IN && acc_lock && !FETCH_FLASH_IN |=> TRAP_OUT &&
		DATA_RDATA_OUT == DUMMY_DATA && TRAP_CODE_OUT == TRAP_CODE)
		else $error("locked read not trapped");

	a_step_order: assert property (
		loaded && !dis_ok[0] |=> prot_q.dis[0] == $past(prot_q.dis[0]))
		else $error("disable step 0 out of order");

	a_lock_hides_read: assert property (
		PSEL_IN && !PENABLE_IN && !PWRITE_IN && LOCK_IN &&
		PADDR_IN != ADDR_STATUS |=> PRDATA_OUT == DUMMY_DATA)
		else $error("register read while locked");

	a_wfault_set: assert property (
		fault_done && FAULT_IN.write_err |=> fault_q[FB_WRITE])
		else $error("write fault not latched");

	a_erase_set: assert property (
		fault_done && FAULT_IN.erase_err |=>
		fault_q[FB_ERASE] && fault_q[FB_WRITE])
		else $error("erase fault not latched");

	a_prog_set: assert property (
		fault_done && FAULT_IN.prog_err |=> fault_q[FB_WRITE])
		else $error("program fault did not mark write fault");

	a_onez_set: assert property (
		fault_done && FAULT_IN.one_zero |=> fault_q[FB_ONEZ])
		else $error("one over zero fault not latched");

	a_resume_abort: assert property (
		fault_done && FAULT_IN.resume_err |->
		OP_ABORT_OUT ##1 fault_q[FB_RESUME])
		else $error("bad resume not aborted");

	a_wprot_prog: assert property (
		fault_done && PROG_OP_IN &&
		!SECTOR_WR_EN_OUT[OP_SECTOR_IN] |=> fault_q[FB_WPROT])
		else $error("locked sector write not flagged");

	a_sector_lock: assert property (
		!prot_q.wlock[OP_SECTOR_IN] |-> !SECTOR_WR_EN_OUT[OP_SECTOR_IN])
		else $error("locked sector left writable");

	a_locked_write: assert property (
		DATA_WR_IN && acc_lock && !FETCH_FLASH_IN |-> !DATA_WR_OK_OUT)
		else $error("data write passed the access lock");

	a_debug_lock: assert property (
		!prot_q.alock[AB_DEBUG] |-> !DEBUG_EN_OUT && !BYPASS_ALL_OUT)
		else $error("debug open while locked");

	a_step_opens: assert property (
		loaded && steps_off |-> !acc_lock)
		else $error("open step left access lock on");

	a_step_closes: assert property (
		loaded && !prot_q.alock[AB_ACCESS] && !tau_q &&
		!steps_off |-> acc_lock)
		else $error("access lock not restored");

	a_dis_order: assert property (
		loaded |=> (~prot_q.dis & $past(prot_q.dis) &
		~$past(dis_ok)) == 16'h0000)
		else $error("disable step out of order");

	a_ren_order: assert property (
		loaded |=> (~prot_q.ren & $past(prot_q.ren) &
		~$past(ren_ok)) == 16'h0000)
		else $error("reenable step out of order");

	a_tau_flash: assert property (
		!tau_q && !FETCH_FLASH_IN |=> !tau_q)
		else $error("temporary unlock set from outside flash");

	c_fault_set: cover property (fault_done && FAULT_IN.wprot);
	c_unlock_tmp: cover property (tau_q && loaded);
	c_step_open: cover property (steps_off && loaded);
	c_trap: cover property (TRAP_OUT);
	c_set_clear: cover property (fault_done && wr_acc &&
		PADDR_IN == ADDR_FAULT);
endmodule : ffp_top
`default_nettype wire

// *** ffp_pkg.sv ***
`default_nettype none
package ffp_pkg;
	// Register byte addresses on the APB bus.
	localparam logic [7:0] ADDR_FAULT = 8'h00;
	localparam logic [7:0] ADDR_NVWL = 8'h04;
	localparam logic [7:0] ADDR_NVAL = 8'h08;
	localparam logic [7:0] ADDR_NVDIS = 8'h0c;
	localparam logic [7:0] ADDR_NVREN = 8'h10;
	localparam logic [7:0] ADDR_UNPROT = 8'h14;
	localparam logic [7:0] ADDR_PROG = 8'h18;
	localparam logic [7:0] ADDR_PROGSEL = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	// Fault register bit positions.
	localparam int FB_WRITE = 0;
	localparam int FB_ERASE = 1;
	localparam int FB_PROG = 2;
	localparam int FB_ONEZ = 3;
	localparam int FB_SEQ = 6;
	localparam int FB_RESUME = 7;
	localparam int FB_WPROT = 8;
	localparam logic [15:0] FAULT_MASK = 16'h01cf;
	localparam int AB_ACCESS = 0;
	localparam int AB_DEBUG = 1;
	localparam int SECTORS = 8;
	localparam int STEPS = 16;
	localparam logic [15:0] NV_ERASED = 16'hffff;
	localparam logic [15:0] PROT_ACTIVE = 16'h0000;
	localparam logic [15:0] FAULT_RST = 16'h0000;
	localparam logic [31:0] DUMMY_DATA = 32'h0000_0000;
	localparam logic [15:0] TRAP_CODE = 16'h009b;
	localparam logic [1:0] SEL_NVWL = 2'h0;
	localparam logic [1:0] SEL_NVAL = 2'h1;
	localparam logic [1:0] SEL_NVDIS = 2'h2;
	localparam logic [1:0] SEL_NVREN = 2'h3;

	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN = 3'b100
	} ffp_state_t;

	typedef struct packed {
		logic done;
		logic write_err;
		logic erase_err;
		logic prog_err;
		logic one_zero;
		logic seq_err;
		logic resume_err;
		logic wprot;
	} ffp_fault_t;

	typedef struct packed {
		logic [15:0] wlock;
		logic [15:0] alock;
		logic [15:0] dis;
		logic [15:0] ren;
	} ffp_prot_t;
endpackage : ffp_pkg
`default_nettype wire

// *** tb.sv ***
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
	import ffp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, pen, pwr, lock, pend, ffl, eop, pop, drd, dwr;
	logic [7:0] paddr, esec;
	logic [2:0] osec;
	logic [31:0] pwd, prd, frd, drdat;
	logic [15:0] nw, na, nd, nr, tcode;
	ffp_fault_t flt;
	logic pready, perr, wok, trap, abort, dbg, byp, alk;
	logic [7:0] swe;
	int miscompares = 0, comparisons = 0, cyc = 0;
	logic [31:0] r;
	ffp_top uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
		.PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
		.LOCK_IN(lock), .PENDING_IN(pend), .FETCH_FLASH_IN(ffl),
		.FAULT_IN(flt), .ERASE_OP_IN(eop), .PROG_OP_IN(pop),
		.OP_SECTOR_IN(osec), .ERASE_SECTORS_IN(esec), .NV_WLOCK_IN(nw),
		.NV_ALOCK_IN(na), .NV_DIS_IN(nd), .NV_REN_IN(nr), .DATA_RD_IN(drd),
		.DATA_WR_IN(dwr), .FLASH_RDATA_IN(frd), .DATA_RDATA_OUT(drdat),
		.DATA_WR_OK_OUT(wok), .TRAP_OUT(trap), .TRAP_CODE_OUT(tcode),
		.SECTOR_WR_EN_OUT(swe), .OP_ABORT_OUT(abort), .DEBUG_EN_OUT(dbg),
		.BYPASS_ALL_OUT(byp), .ACCESS_LOCK_OUT(alk));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= d;
		@(posedge clk);
		pen <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prd;
		`CHK("pslverr", 1'b0, perr)
		psel <= 0;
		pen <= 0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr
	task automatic do_reset(input logic [15:0] w, a, d, e);
		@(posedge clk);
		rst_n <= 0; nw <= w; na <= a; nd <= d; nr <= e;
		repeat (2) @(posedge clk);
		`CHK("swe_rst", 8'h00, swe)
		`CHK("alk_rst", 1'b1, alk)
		`CHK("dbg_rst", 1'b0, dbg)
		rst_n <= 1;
		repeat (3) @(posedge clk);
	endtask : do_reset
	task automatic op(input ffp_fault_t f);
		@(posedge clk);
		pend <= 1;
		@(posedge clk);
		pend <= 0; flt <= f;
		#1 `CHK("abort", f.resume_err, abort)
		@(posedge clk);
		flt <= '0; eop <= 0; pop <= 0;
	endtask : op
	task automatic t_faults();
		ffp_fault_t f;
		logic [15:0] ex [6] = '{16'h0001, 16'h0003, 16'h0005, 16'h0008,
			16'h0041, 16'h0080};
		do_reset(16'hfff0, NV_ERASED, NV_ERASED, NV_ERASED);
		`CHK("swe", 8'hf0, swe)
		apb(1'b0, ADDR_NVWL, '0, r);
		`CHK("nvwl", 32'h0000fff0, r)
		`CHK("dbg", 1'b1, byp)
		f = '0; f.done = 1; f.erase_err = 1;
		@(posedge clk);
		pend <= 1; flt <= f;
		apb(1'b0, ADDR_FAULT, '0, r);
		`CHK("fault_pend", 32'h0, r)
		flt <= '0;
		pend <= 0;
		for (int i = 0; i < 6; i++) begin
			f = '0; f.done = 1;
			f.write_err = (i == 0); f.erase_err = (i == 1);
			f.prog_err = (i == 2); f.one_zero = (i == 3);
			f.seq_err = (i == 4); f.resume_err = (i == 5);
			op(f);
			lock <= 1;
			apb(1'b0, ADDR_FAULT, '0, r);
			`CHK("fault_lock", 32'h0, r)
			lock <= 0;
			apb(1'b0, ADDR_FAULT, '0, r);
			`CHK("fault", {16'h0, ex[i]}, r)
			wr(ADDR_FAULT, 32'h0);
			apb(1'b0, ADDR_FAULT, '0, r);
			`CHK("fault_clr", 32'h0, r)
		end
		f = '0; f.done = 1; f.erase_err = 1;
		@(posedge clk);
		pend <= 1;
		fork
			wr(ADDR_FAULT, 32'h0);
			begin
				@(posedge clk);
				@(posedge clk);
				pend <= 0; flt <= f;
				@(posedge clk);
				flt <= '0;
			end
		join
		apb(1'b0, ADDR_FAULT, '0, r);
		`CHK("set_wins", 32'h0003, r)
		f = '0; f.done = 1; pop <= 1; osec <= 3'h0;
		op(f);
		apb(1'b0, ADDR_FAULT, '0, r);
		`CHK("wprot", 1'b1, r[FB_WPROT])
	endtask : t_faults
	task automatic t_access();
		do_reset(NV_ERASED, 16'hfffe, NV_ERASED, NV_ERASED);
		`CHK("alk_on", 1'b1, alk)
		dwr <= 1;
		@(posedge clk);
		`CHK("wok", 1'b0, wok)
		ffl <= 1;
		@(posedge clk);
		`CHK("wok_flash", 1'b1, wok)
		ffl <= 0;
		dwr <= 0;
		@(posedge clk);
		drd <= 1;
		@(posedge clk);
		drd <= 0;
		#1 `CHK("trap", 1'b1, trap)
		`CHK("tcode", TRAP_CODE, tcode)
		`CHK("dummy", DUMMY_DATA, drdat)
		@(posedge clk);
		#1 `CHK("pass_data", frd, drdat)
		ffl <= 1;
		wr(ADDR_UNPROT, 32'h1);
		ffl <= 0;
		@(posedge clk);
		`CHK("temp_unlk", 1'b0, alk)
		do_reset(NV_ERASED, 16'hfffc, 16'hfffe, NV_ERASED);
		`CHK("alk_dis", 1'b0, alk)
		`CHK("dbg_off", 1'b0, dbg)
		do_reset(NV_ERASED, 16'hfffc, 16'hfffe, 16'hfffe);
		`CHK("alk_ren", 1'b1, alk)
	endtask : t_access
	task automatic prog(input logic [1:0] s, input logic [15:0] d,
		input logic [7:0] a, input logic [15:0] e);
		wr(ADDR_PROGSEL, {30'h0, s});
		wr(ADDR_PROG, {16'h0, d});
		apb(1'b0, a, '0, r);
		`CHK("nv_prog", {16'h0, e}, r)
	endtask : prog
	task automatic t_prog();
		do_reset(NV_ERASED, NV_ERASED, NV_ERASED, NV_ERASED);
		prog(SEL_NVWL, 16'hfffe, ADDR_NVWL, 16'hfffe);
		prog(SEL_NVWL, 16'hffff, ADDR_NVWL, 16'hfffe);
		ffl <= 1;
		prog(SEL_NVWL, 16'hfff0, ADDR_NVWL, 16'hfffe);
		ffl <= 0;
		prog(SEL_NVDIS, 16'hfffe, ADDR_NVDIS, 16'hffff);
		ffl <= 1;
		wr(ADDR_UNPROT, 32'h1);
		ffl <= 0;
		prog(SEL_NVAL, 16'hfffc, ADDR_NVAL, 16'hfffc);
		prog(SEL_NVREN, 16'hfffe, ADDR_NVREN, 16'hffff);
		prog(SEL_NVDIS, 16'hfffe, ADDR_NVDIS, 16'hfffe);
		prog(SEL_NVDIS, 16'hfffc, ADDR_NVDIS, 16'hfffe);
		prog(SEL_NVREN, 16'hfffe, ADDR_NVREN, 16'hfffe);
		prog(SEL_NVDIS, 16'hfffc, ADDR_NVDIS, 16'hfffc);
		apb(1'b0, 8'h3c, '0, r);
		`CHK("unmapped", 32'h0, r)
	endtask : t_prog
	initial begin
		rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = '0; pwd = '0;
		lock = 0; pend = 0; ffl = 0; flt = '0; eop = 0; pop = 0;
		osec = '0; esec = '0; drd = 0; dwr = 0; frd = 32'h1234_5678;
		nw = NV_ERASED; na = NV_ERASED; nd = NV_ERASED; nr = NV_ERASED;
		t_faults();
		t_access();
		t_prog();
		close_out();
	end
endmodule : tb
`default_nettype wire
